// ===== hw/mmr_map.vh
`ifndef MMR_MAP_VH
`define MMR_MAP_VH

// Register byte offsets
`define MMR_OFS_CTRL 8'h00
`define MMR_OFS_STATUS 8'h04
`define MMR_OFS_RESULT 8'h08

// Control register fields and reset value
`define MMR_CTRL_HOLD 0
`define MMR_CTRL_RESET 1'b0

// Status register field positions
`define MMR_ST_FUNC_LO 0
`define MMR_ST_COUPLING 2
`define MMR_ST_LPO 3
`define MMR_ST_MANUAL 4
`define MMR_ST_RANGE_LO 5
`define MMR_ST_PHASE_LO 8

// Result register field positions
`define MMR_RS_READING_LO 0
`define MMR_RS_OVR 12
`define MMR_RS_EXT 13
`define MMR_RS_BAR_LO 14
`define MMR_RS_BAR_OVR 20
`define MMR_RS_BUZZER 21

// Measurement function codes
`define MMR_FN_VOLT 2'h0
`define MMR_FN_RES 2'h1
`define MMR_FN_CUR 2'h2

// Range indices
`define MMR_RANGE_LOW 3'h0
`define MMR_RANGE_SECOND 3'h1
`define MMR_RANGE_TOP 3'h4
`define MMR_RANGE_CUR_TOP 3'h1

// Conversion timing in internal clock periods
`define MMR_CONV_PERIODS 8000
// Integrate time in crystal periods: 1638.5 internal periods
`define MMR_INT_XTAL 3277
`define MMR_CAP_EXT 3000
`define MMR_CAP_STD 2000

// Count thresholds
`define MMR_DOWNRANGE_BELOW 180
`define MMR_CONTINUITY_BELOW 19
`define MMR_BUZZ_ABOVE 2000
`define MMR_EXT_ABOVE 1999
`define MMR_BAR_FULL 40
`define MMR_BAR_OVR_ABOVE 2024
`define MMR_BAR_STEP 50
`define MMR_BAR_ROUND 25

`endif

// ===== hw/mmr_pin_sync.v
`default_nettype none

module mmr_pin_sync (
    input wire pclk,
    input wire presetn,
    input wire [7:0] pins_raw,
    output wire [7:0] pins_level,
    output wire [7:0] pins_fall,
    output wire [7:0] pins_rise
);

    reg [7:0] s1_reg;
    reg [7:0] s2_reg;
    reg [7:0] s3_reg;

    // Two-stage synchroniser plus a history stage for edges;
    // reset high because the pins idle pulled up
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= 8'hff;
            s2_reg <= 8'hff;
            s3_reg <= 8'hff;
        end
        else
        begin
            s1_reg <= pins_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // One pulse per press, never one per clock of a held button
    assign pins_level = s2_reg;
    assign pins_fall = s3_reg & ~s2_reg;
    assign pins_rise = s2_reg & ~s3_reg;

endmodule // mmr_pin_sync

`default_nettype wire

// ===== hw/mmr_bar_map.v
`default_nettype none
`include "mmr_map.vh"

module mmr_bar_map (
    input wire pclk,
    input wire presetn,
    input wire [11:0] reading,
    input wire overrange,
    input wire ext_high,
    output reg [5:0] segments,
    output reg bar_ovr
);

    // Round to nearest 50 counts, clipped to the full bar
    function [5:0] bar_count;
        input [11:0] value;
        reg [11:0] steps;
        begin
            steps = (value + 12'd`MMR_BAR_ROUND) / 12'd`MMR_BAR_STEP;
            if (steps > 12'd`MMR_BAR_FULL)
                bar_count = 6'd`MMR_BAR_FULL;
            else
                bar_count = steps[5:0];
        end
    endfunction

    // Registered so the driver sees stable segment data
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            segments <= 6'h00;
            bar_ovr <= 1'b0;
        end
        else if (overrange)
        begin
            segments <= 6'd`MMR_BAR_FULL;
            bar_ovr <= 1'b1;
        end
        else if (ext_high)
        begin
            segments <= 6'd`MMR_BAR_FULL;
            bar_ovr <= 1'b0;
        end
        else
        begin
            segments <= bar_count(reading);
            bar_ovr <= (reading > 12'd`MMR_BAR_OVR_ABOVE);
        end
    end

endmodule // mmr_bar_map

`default_nettype wire

// ===== hw/mmr_sequencer.v
// Notes on behaviour
// - Function from ohms/current selects: 00 volt, 01 ohm, 10 amp, 11 volt.
// - Bar segments: 0-24 none, 50N+-25 gives N, above 2024 overrange unless extended.
// - In ohms, each option press toggles low-power ohms; off at reset.
// - Manual ranging ends when function or option changes; back to auto, except in current.
// - Low-power ohms never uses the lowest 200 ohm range.
// - DC at reset; each coupling press toggles COUPLING_TOGGLE_N, AC lamp lit; in ohms the press is ignored.
// - Lowest voltage range: 2 V in AC, 200 mV in DC.
// - Current is manual only, low_current_range_n and 200 mA ranges, AC or DC.
// - Low-current pin floating gives 200 mA, grounded gives low_current_range_n.
// - Crystal halved to internal clock; conversion is 8000 periods.
// - Integrate phase is always 1638.5 internal periods.
// - Deintegrate cap 3000 extended, 2000 otherwise; rest is auto-zero.
// - Zero crossing in deintegrate ends it and enters auto-zero.
// - Range press in auto volt/ohm goes manual on current range.
// - Each range press in manual volts or ohms steps to the next range; in current it is ignored.
// - Reset starts in auto-ranging.
// - Manual ranging raises the count limit from 2000 to 3000.
// - Auto extended resolution only on top volt and top ohm range.
// - Extended reading over 1999: blinking 1, lower digits, full bar.
// - Overrange blinks the top digit and zeroes the lower digits.
// - Volt and amp readings over 2000 enable the buzzer.
// - Ohms buzzer only for continuity below 19, never for overrange.
// - Auto reading below 180 tries the next more sensitive range.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`default_nettype none
`include "mmr_map.vh"

module mmr_sequencer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire xtal_clk,
    input wire ohms_select_n,
    input wire current_select_n,
    input wire coupling_toggle_n,
    input wire low_power_ohms_toggle_n,
    input wire range_step_n,
    input wire low_current_range_n,
    input wire zero_cross,
    output reg internal_clk,
    output reg autozero_active,
    output reg integrate_active,
    output reg deint_active,
    output reg [1:0] function_code,
    output reg [2:0] range_code,
    output reg ac_indicator,
    output reg low_power_ohms_indicator,
    output reg auto_indicator,
    output reg [11:0] reading,
    output reg top_digit_blink,
    output reg top_digit_one,
    output reg lower_digits_zero,
    output reg [9:0] lower_digits,
    output reg buzzer_enable,
    output wire [5:0] bar_segments,
    output wire bar_overrange
);

    localparam [2:0] ST_AZ = 3'b001;
    localparam [2:0] ST_INT = 3'b010;
    localparam [2:0] ST_DEINT = 3'b100;
    localparam [13:0] CONV_XTAL = 14'd`MMR_CONV_PERIODS * 14'd2;
    localparam [13:0] INT_XTAL = 14'd`MMR_INT_XTAL;
    localparam [12:0] CAP_EXT_XTAL = 13'd`MMR_CAP_EXT * 13'd2;
    localparam [12:0] CAP_STD_XTAL = 13'd`MMR_CAP_STD * 13'd2;

    wire [7:0] pin_level;
    wire [7:0] pin_fall;
    wire [7:0] pin_rise;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [13:0] conv_cnt_reg;
    reg [12:0] deint_cnt_reg;
    reg done_reg;
    reg done_ovr_reg;
    reg [11:0] done_count_reg;
    reg hold_reg;
    reg [1:0] func_reg;
    reg ac_reg;
    reg lpo_reg;
    reg manual_reg;
    reg [2:0] range_reg;
    reg ovr_reg;
    reg ext_reg;
    wire xtal_tick;
    wire [1:0] func_now;
    wire ext_mode;
    wire [12:0] cap_xtal;
    wire ext_high;
    wire apb_setup;
    wire apb_write;
    wire addr_hit;
    wire [11:0] digits_mod;

    // Every pin is asynchronous to pclk
    mmr_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins_raw({zero_cross, low_current_range_n, range_step_n,
            low_power_ohms_toggle_n, coupling_toggle_n, current_select_n,
            ohms_select_n, xtal_clk}),
        .pins_level(pin_level),
        .pins_fall(pin_fall),
        .pins_rise(pin_rise)
    );

    // Truth table of the two select pins
    function [1:0] decode_func;
        input ohm_n;
        input cur_n;
        begin
            case ({ohm_n, cur_n})
                2'b01: decode_func = `MMR_FN_RES;
                2'b10: decode_func = `MMR_FN_CUR;
                default: decode_func = `MMR_FN_VOLT;
            endcase
        end
    endfunction

    // Most sensitive range allowed for function and options
    function [2:0] range_floor;
        input [1:0] fn;
        input ac;
        input lpo;
        begin
            if (fn == `MMR_FN_VOLT && ac)
                range_floor = `MMR_RANGE_SECOND;
            else if (fn == `MMR_FN_RES && lpo)
                range_floor = `MMR_RANGE_SECOND;
            else
                range_floor = `MMR_RANGE_LOW;
        end
    endfunction

    // Least sensitive range for the function
    function [2:0] range_ceiling;
        input [1:0] fn;
        begin
            if (fn == `MMR_FN_CUR)
                range_ceiling = `MMR_RANGE_CUR_TOP;
            else
                range_ceiling = `MMR_RANGE_TOP;
        end
    endfunction

    assign func_now = decode_func(pin_level[1], pin_level[2]);
    // Crystal periods are counted so the half-period integrate fits
    assign xtal_tick = pin_rise[0];

    // Auto extended resolution only on the top volt or ohm range
    assign ext_mode = manual_reg || (range_reg == `MMR_RANGE_TOP);
    assign cap_xtal = ext_mode ? CAP_EXT_XTAL : CAP_STD_XTAL;

    // Divide the crystal by two for the internal clock
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            internal_clk <= 1'b0;
        else if (xtal_tick)
            internal_clk <= ~internal_clk;
    end

    // Phase sequencer; one-hot state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_AZ:
                if (xtal_tick && conv_cnt_reg == CONV_XTAL - 14'd1)
                    state_next = ST_INT;
            ST_INT:
                if (xtal_tick && conv_cnt_reg == INT_XTAL - 14'd1)
                    state_next = ST_DEINT;
            ST_DEINT:
                if (pin_rise[7])
                    state_next = ST_AZ;
                else if (xtal_tick && deint_cnt_reg == cap_xtal - 13'd1)
                    state_next = ST_AZ;
            default:
                state_next = ST_AZ;
        endcase
    end

    // Conversion counter runs unbroken, so auto-zero soaks up the
    // unused deintegrate time and each conversion keeps its length
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_AZ;
            conv_cnt_reg <= 14'h0000;
            deint_cnt_reg <= 13'h0000;
            done_reg <= 1'b0;
            done_ovr_reg <= 1'b0;
            done_count_reg <= 12'h000;
        end
        else
        begin
            state_reg <= state_next;
            done_reg <= 1'b0;
            if (xtal_tick)
            begin
                if (state_reg == ST_AZ && state_next == ST_INT)
                    conv_cnt_reg <= 14'h0000;
                else
                    conv_cnt_reg <= conv_cnt_reg + 14'd1;
            end
            if (state_reg == ST_INT)
                deint_cnt_reg <= 13'h0000;
            else if (state_reg == ST_DEINT && xtal_tick)
                deint_cnt_reg <= deint_cnt_reg + 13'd1;
            if (state_reg == ST_DEINT && state_next == ST_AZ)
            begin
                done_reg <= 1'b1;
                done_ovr_reg <= ~pin_rise[7];
                // Count in internal periods; cap reports the limit itself
                if (pin_rise[7])
                    done_count_reg <= deint_cnt_reg[12:1];
                else
                    done_count_reg <= cap_xtal[12:1];
            end
        end
    end

    // Function, options and range; a change of function (except into current)
    // or of option in volts or ohms drops manual ranging before any range press is looked at
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            func_reg <= `MMR_FN_VOLT;
            ac_reg <= 1'b0;
            lpo_reg <= 1'b0;
            manual_reg <= 1'b0;
            range_reg <= `MMR_RANGE_LOW;
        end
        else if (func_now != func_reg)
        begin
            func_reg <= func_now;
            manual_reg <= (func_now == `MMR_FN_CUR);
            range_reg <= range_floor(func_now, ac_reg, lpo_reg);
        end
        else if (func_reg == `MMR_FN_CUR)
        begin
            // Current range follows its pin alone
            manual_reg <= 1'b1;
            range_reg <= pin_level[6] ? `MMR_RANGE_CUR_TOP
                : `MMR_RANGE_LOW;
            if (pin_fall[3])
                ac_reg <= ~ac_reg;
        end
        else if (func_reg == `MMR_FN_VOLT && pin_fall[3])
        begin
            ac_reg <= ~ac_reg;
            manual_reg <= 1'b0;
            range_reg <= range_floor(func_reg, ~ac_reg, lpo_reg);
        end
        else if (func_reg == `MMR_FN_RES && pin_fall[4])
        begin
            lpo_reg <= ~lpo_reg;
            manual_reg <= 1'b0;
            range_reg <= range_floor(func_reg, ac_reg, ~lpo_reg);
        end
        else if (pin_fall[5])
        begin
            if (!manual_reg)
                manual_reg <= 1'b1;
            else if (range_reg >= range_ceiling(func_reg))
                range_reg <= range_floor(func_reg, ac_reg, lpo_reg);
            else
                range_reg <= range_reg + 3'd1;
        end
        else if (done_reg && !manual_reg)
        begin
            // Auto-ranging decision after each conversion
            if (done_ovr_reg && range_reg < range_ceiling(func_reg))
                range_reg <= range_reg + 3'd1;
            else if (!done_ovr_reg
                && done_count_reg < 12'd`MMR_DOWNRANGE_BELOW
                && range_reg > range_floor(func_reg, ac_reg, lpo_reg))
                range_reg <= range_reg - 3'd1;
        end
    end

    // Latched result; hold freezes the display between conversions
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reading <= 12'h000;
            ovr_reg <= 1'b0;
            ext_reg <= 1'b0;
        end
        else if (done_reg && !hold_reg)
        begin
            reading <= done_count_reg;
            ovr_reg <= done_ovr_reg;
            ext_reg <= ext_mode;
        end
    end

    assign ext_high = ext_reg && !ovr_reg
        && reading > 12'd`MMR_EXT_ABOVE;

    // Remainder stays below 1000, so ten bits always hold it
    assign digits_mod = reading % 12'd1000;

    // Digit formatting and buzzer, registered for the display driver
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            top_digit_blink <= 1'b0;
            top_digit_one <= 1'b0;
            lower_digits_zero <= 1'b0;
            lower_digits <= 10'h000;
            buzzer_enable <= 1'b0;
        end
        else
        begin
            top_digit_blink <= ovr_reg || ext_high;
            top_digit_one <= ext_high;
            lower_digits_zero <= ovr_reg;
            if (ovr_reg)
                lower_digits <= 10'h000;
            else
                lower_digits <= digits_mod[9:0];
            if (func_reg == `MMR_FN_RES)
                buzzer_enable <= !ovr_reg
                    && reading < 12'd`MMR_CONTINUITY_BELOW;
            else
                buzzer_enable <= ovr_reg
                    || reading > 12'd`MMR_BUZZ_ABOVE;
        end
    end

    // Status pins follow the internal state one clock later
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            autozero_active <= 1'b1;
            integrate_active <= 1'b0;
            deint_active <= 1'b0;
            function_code <= `MMR_FN_VOLT;
            range_code <= `MMR_RANGE_LOW;
            ac_indicator <= 1'b0;
            low_power_ohms_indicator <= 1'b0;
            auto_indicator <= 1'b1;
        end
        else
        begin
            autozero_active <= state_reg[0];
            integrate_active <= state_reg[1];
            deint_active <= state_reg[2];
            function_code <= func_reg;
            range_code <= range_reg;
            ac_indicator <= ac_reg
                && func_reg != `MMR_FN_RES;
            low_power_ohms_indicator <= lpo_reg
                && func_reg == `MMR_FN_RES;
            auto_indicator <= ~manual_reg;
        end
    end

    mmr_bar_map u_bar (
        .pclk(pclk),
        .presetn(presetn),
        .reading(reading),
        .overrange(ovr_reg),
        .ext_high(ext_high),
        .segments(bar_segments),
        .bar_ovr(bar_overrange)
    );

    // APB slave: no wait states, error on unmapped offsets
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign addr_hit = paddr == `MMR_OFS_CTRL || paddr == `MMR_OFS_STATUS
        || paddr == `MMR_OFS_RESULT;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // Control register write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_reg <= `MMR_CTRL_RESET;
        else if (apb_write && paddr == `MMR_OFS_CTRL)
            hold_reg <= pwdata[`MMR_CTRL_HOLD];
    end

    // Read data captured in the setup cycle, stable through access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_setup)
        begin
            prdata <= 32'h00000000;
            case (paddr)
                `MMR_OFS_CTRL:
                    prdata[`MMR_CTRL_HOLD] <= hold_reg;
                `MMR_OFS_STATUS:
                begin
                    prdata[`MMR_ST_FUNC_LO +: 2] <= func_reg;
                    prdata[`MMR_ST_COUPLING] <= ac_reg;
                    prdata[`MMR_ST_LPO] <= lpo_reg;
                    prdata[`MMR_ST_MANUAL] <= manual_reg;
                    prdata[`MMR_ST_RANGE_LO +: 3] <= range_reg;
                    prdata[`MMR_ST_PHASE_LO +: 3] <= state_reg;
                end
                `MMR_OFS_RESULT:
                begin
                    prdata[`MMR_RS_READING_LO +: 12] <= reading;
                    prdata[`MMR_RS_OVR] <= ovr_reg;
                    prdata[`MMR_RS_EXT] <= ext_reg;
                    prdata[`MMR_RS_BAR_LO +: 6] <= bar_segments;
                    prdata[`MMR_RS_BAR_OVR] <= bar_overrange;
                    prdata[`MMR_RS_BUZZER] <= buzzer_enable;
                end
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // mmr_sequencer

`default_nettype wire

// ===== verif/mmr_props.sv
`default_nettype none
module mmr_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ohms_select_n,
    input wire logic current_select_n,
    input wire logic low_current_range_n,
    input wire logic deint_active,
    input wire logic [1:0] function_code,
    input wire logic [2:0] range_code,
    input wire logic ac_indicator,
    input wire logic low_power_ohms_indicator,
    input wire logic auto_indicator,
    input wire logic [11:0] reading,
    input wire logic top_digit_blink,
    input wire logic lower_digits_zero,
    input wire logic [9:0] lower_digits,
    input wire logic buzzer_enable,
    input wire logic [5:0] bar_segments
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [1:0] fn_exp;
    wire [12:0] bar_q;
    wire [5:0] bar_exp;
    wire buz_exp;
    // Expected decode, bar and buzzer; bar is computed wide to dodge wrap
    assign fn_exp = (!ohms_select_n && current_select_n) ? 2'h1 :
        (ohms_select_n && !current_select_n) ? 2'h2 : 2'h0;
    assign bar_q = ({1'b0, reading} + 13'h0019) / 13'h0032;
    assign bar_exp = (lower_digits_zero || reading > 12'h7cf ||
        bar_q > 13'h0028) ? 6'h28 : bar_q[5:0];
    assign buz_exp = (function_code == 2'h1) ?
        (!lower_digits_zero && reading < 12'h013) :
        (lower_digits_zero || reading > 12'h7d0);
    sequence s_sel_steady;
        $stable({ohms_select_n, current_select_n})[*6];
    endsequence
    sequence s_amp_steady;
        (function_code == 2'h2 && $stable(low_current_range_n))[*5];
    endsequence
    sequence s_done;
        $fell(deint_active) ##3 1'b1;
    endsequence
    property p_func_decode;
        s_sel_steady |-> function_code == fn_exp;
    endproperty
    property p_lpo_floor;
        low_power_ohms_indicator && function_code == 2'h1 |-> range_code != 0;
    endproperty
    property p_ac_floor;
        ac_indicator && function_code == 2'h0 |-> range_code != 3'h0;
    endproperty
    property p_amp_manual;
        function_code == 2'h2 |-> !auto_indicator;
    endproperty
    property p_amp_range;
        s_amp_steady |-> range_code == {2'h0, low_current_range_n};
    endproperty
    property p_bar;
        s_done |-> bar_segments == bar_exp;
    endproperty
    property p_buzz;
        s_done |-> buzzer_enable == buz_exp;
    endproperty
    property p_ovr_digits;
        lower_digits_zero |-> top_digit_blink && lower_digits == 10'h000;
    endproperty
    a_func_decode: assert property (p_func_decode)
        else $error("function code does not follow selects");
    a_lpo_floor: assert property (p_lpo_floor)
        else $error("low power ohms on lowest range");
    a_ac_floor: assert property (p_ac_floor)
        else $error("ac voltage on lowest range");
    a_amp_manual: assert property (p_amp_manual)
        else $error("current in auto ranging");
    a_amp_range: assert property (p_amp_range)
        else $error("current range does not follow pin");
    a_bar: assert property (p_bar)
        else $error("bar segments wrong");
    a_buzz: assert property (p_buzz)
        else $error("buzzer wrong");
    a_ovr_digits: assert property (p_ovr_digits)
        else $error("overrange digits wrong");
endmodule // mmr_props
bind mmr_sequencer mmr_props mmr_props_inst (.*);
`default_nettype wire

// ===== verif/mmr_panel.sv
`default_nettype none
module mmr_panel #(
    parameter int DLY = 150
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic deint_active,
    input wire logic stuck,
    output logic xtal_clk,
    output logic zero_cross
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Fast crystal keeps a conversion short; comparator trips at a fixed
    // deintegrate time, which stands for one steady input level;
    // stuck never trips it, an input beyond full scale
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xtal_clk <= 1'b0;
            cnt <= 0;
            zero_cross <= 1'b0;
        end
        else
        begin
            xtal_clk <= ~xtal_clk;
            cnt <= deint_active ? cnt + 1 : 0;
            zero_cross <= deint_active && !stuck && cnt >= DLY * 4;
        end
    end
endmodule // mmr_panel
`default_nettype wire

// ===== verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic xtal_clk, zero_cross, ohms_select_n, current_select_n;
    logic low_current_range_n, internal_clk, autozero_active;
    logic integrate_active, deint_active, ac_indicator, auto_indicator;
    logic low_power_ohms_indicator, top_digit_blink, top_digit_one;
    logic lower_digits_zero, buzzer_enable, bar_overrange, stuck;
    wire coupling_toggle_n, low_power_ohms_toggle_n, range_step_n;
    logic [1:0] function_code;
    logic [2:0] range_code, btn_n;
    logic [11:0] reading;
    logic [9:0] lower_digits;
    logic [5:0] bar_segments;
    int errors, compares, cyc = 0, t0;
    assign {range_step_n, low_power_ohms_toggle_n, coupling_toggle_n} = btn_n;
    mmr_sequencer mmr_sequencer_inst (.*);
    mmr_panel mmr_panel_inst (.pclk(pclk), .presetn(presetn),
        .deint_active(deint_active), .stuck(stuck), .xtal_clk(xtal_clk),
        .zero_cross(zero_cross));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task finish_test;
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Cycle count doubles as the hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            errors++;
            finish_test();
        end
    end
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %s exp %h got %h", what, e, g);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Presses are held well past the two-flop synchroniser
    task press(input int i);
        btn_n[i] <= 1'b0;
        repeat (4) @(posedge pclk);
        btn_n[i] <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
    task sel(input logic [1:0] s);
        {ohms_select_n, current_select_n} <= s;
        repeat (8) @(posedge pclk);
    endtask
    initial
    begin
        errors = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        btn_n = 3'h7;
        stuck = 1'b0;
        ohms_select_n = 1'b1;
        current_select_n = 1'b1;
        low_current_range_n = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("auto", 1, auto_indicator);
        chk("ac", 0, ac_indicator);
        chk("lpo", 0, low_power_ohms_indicator);
        chk("az", 1, autozero_active);
        while (integrate_active !== 1'b1) @(posedge pclk);
        t0 = cyc;
        while (integrate_active === 1'b1) @(posedge pclk);
        chk("int_len", 6554, cyc - t0);
        while (deint_active !== 1'b0) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk("reading", 1, reading >= 150 && reading <= 153);
        chk("bar", 3, bar_segments);
        chk("buzz", 0, buzzer_enable);
        chk("range", 0, range_code);
        while (integrate_active !== 1'b1) @(posedge pclk);
        chk("conv", 32000, cyc - t0);
        // Next conversion never crosses zero, so it runs to the cap
        stuck <= 1'b1;
        press(2);
        chk("auto", 0, auto_indicator);
        chk("range", 0, range_code);
        press(2);
        chk("range", 1, range_code);
        press(0);
        chk("auto", 1, auto_indicator);
        chk("ac", 1, ac_indicator);
        chk("range", 1, range_code);
        press(0);
        chk("ac", 0, ac_indicator);
        sel(2'h1);
        press(1);
        chk("lpo", 1, low_power_ohms_indicator);
        chk("range", 1, range_code);
        press(2);
        press(1);
        chk("auto", 1, auto_indicator);
        sel(2'h2);
        chk("auto", 0, auto_indicator);
        chk("range", 1, range_code);
        low_current_range_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("range", 0, range_code);
        press(0);
        chk("ac", 1, ac_indicator);
        apb(1'b0, 8'h04, 32'h0);
        chk("status", 32'h216, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h2, {err, rd != 32'h0});
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h1, rd);
        // Release hold so the capped reading reaches the display
        apb(1'b1, 8'h00, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            sel(i[1:0]);
            chk("func", i == 1 ? 1 : i == 2 ? 2 : 0, function_code);
        end
        // Volt auto on range 1: deintegrate stops at the 2000 cap
        while (deint_active !== 1'b1) @(posedge pclk);
        while (deint_active !== 1'b0) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk("cap", 2000, reading);
        chk("ovr", 3, {top_digit_blink, lower_digits_zero});
        chk("digits", 0, lower_digits);
        chk("buzz", 1, buzzer_enable);
        chk("bar", 32'h68, {bar_overrange, bar_segments});
        finish_test();
    end
endmodule // testbench
`default_nettype wire
